// ==== rtl/sswc_core.v ====
// Serial snooze wake controller: standby, snooze and normal modes around
// one asynchronous receive channel, with its register port and interrupts.
// Assumes a single 40 MHz clock from the fast on-chip oscillator and a
// register master that never sees wait states.
//
// Functional notes
// - Standby plus receive-pin falling edge enters snooze
// - Receiver starts only after oscillator settling time
// - Snooze wake only on channel 5, async
// - Snooze reception samples late, limiting bit rate
// - Snooze runs fast oscillator only, others stopped
// - After character, act per select and release settings
// - Enabled release source raises wake irq, normal mode
// - Wake irq and originating receive irq both presented
// - Select 10b: mismatch returns to standby
// - Error release enable makes errors wake sources
// - Full select 01b makes full a wake source
// - Wake irq forwarded only when enable bit set
// - Selected source always cancels snooze; irq only with enable bit
// - Wake irq also fires outside snooze
`include "sswc_map.vh"
`default_nettype none

module sswc_core #(
   parameter CHAN       = `SSWC_SNZ_CHAN,       // Channel number of this receiver
   parameter SETTLE_CYC = `SSWC_OSC_SETTLE_CYC  // Oscillator settling, cycles
) (
   input  wire        ref_clk_i,               // 40 MHz clock
   input  wire        rst_n_i,                 // Async reset, active low
   input  wire [7:0]  addr_i,                  // Register byte address
   input  wire [31:0] wdata_i,                 // Write data
   input  wire        wr_i,                    // Write strobe
   input  wire        rd_i,                    // Read strobe
   output reg  [31:0] rdata_o,                 // Read data, cycle after rd_i
   input  wire        serial_receive_pin_i,    // Receive line from pin
   output wire        irq_o,                   // Level interrupt
   output reg         snooze_release_irq_o,    // Wake interrupt pulse
   output reg         rx_full_irq_o,           // Receive full pulse
   output reg         rx_err_irq_o,            // Receive error pulse
   output reg         cpu_run_o,               // CPU clock running
   output reg         snooze_o,                // Snooze mode active
   output reg         fast_onchip_osc_en_o,    // Fast oscillator enable
   output reg         slow_onchip_osc_en_o,    // Slow oscillator enable
   output reg         pll_en_o,                // PLL enable
   output reg         main_clk_en_o            // Main clock enable
);

   // Operating modes
   localparam [1:0] M_NORMAL  = 2'h0;
   localparam [1:0] M_STANDBY = 2'h1;
   localparam [1:0] M_SETTLE  = 2'h2;
   localparam [1:0] M_SNZ_RX  = 2'h3;

   // Counts are worked out at full width, then cut to the 16-bit settle timer
   localparam integer SETTLE_LAST_I = SETTLE_CYC - 1;
   localparam integer START_LAG_I   = SETTLE_CYC + `SSWC_SYNC_LAT_CYC;
   localparam [15:0]  SETTLE_LAST   = SETTLE_LAST_I[15:0];
   localparam [15:0]  START_LAG     = START_LAG_I[15:0];

   // Software registers
   reg  [1:0]  snz_sel;                        // serial_snooze_select
   reg         async_mode;
   reg         match_en;
   reg         rx_error_release_enable;
   reg  [1:0]  rx_full_release_select;
   reg         wake_irq_enable_bit;
   reg  [7:0]  compare_data_value;
   reg  [15:0] baud_div;
   reg  [`SSWC_ST_W-1:0] irq_stat;
   reg  [`SSWC_ST_W-1:0] irq_mask;

   // Mode machine
   reg  [1:0]  mode;
   reg  [1:0]  next_mode;
   reg  [15:0] settle_cnt;

   // Pin synchroniser and edge detect
   reg         pin_s1;
   reg         pin_s2;
   reg         pin_prev;
   wire        pin_fall;

   // Receiver hookup
   reg         rx_start;
   reg  [15:0] rx_elapsed;
   reg         rx_late;
   wire        rx_done;
   wire        rx_ferr;
   wire [7:0]  rx_data;
   wire        rx_busy;

   // Event terms
   wire        snz_capable;
   wire        mismatch;
   wire        ev_full;
   wire        ev_err;
   wire        ev_end;
   wire        ev_rel;
   wire        wr_standby;
   wire [`SSWC_ST_W-1:0] stat_set;
   wire        rd_stat;

   // Helper: a one-bit field of the write data
   function wbit;
      input [31:0] d;
      input integer pos;
      begin
         wbit = d[pos];
      end
   endfunction

   // Two flops before anything looks at the pin
   // Reset to the idle level, so leaving reset never fakes a falling edge
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1   <= 1'b1;
         pin_s2   <= 1'b1;
         pin_prev <= 1'b1;
      end else begin
         pin_s1   <= serial_receive_pin_i;
         pin_s2   <= pin_s1;
         pin_prev <= pin_s2;
      end
   end

   assign pin_fall = pin_prev & ~pin_s2;

   // Only the documented channel in async framing can wake from standby
   assign snz_capable = (CHAN == `SSWC_SNZ_CHAN) && async_mode && (snz_sel != `SSWC_SEL_OFF);

   // Character outcome; match detection suppresses full on a mismatch
   // A framing error never counts as data, so error and full never pair
   assign mismatch = match_en && (rx_data != compare_data_value);
   assign ev_err   = rx_done & rx_ferr;
   assign ev_full  = rx_done & ~rx_ferr & ~mismatch;
   assign ev_end   = rx_done & ~rx_ferr & mismatch & (snz_sel == `SSWC_SEL_MISMATCH);

   // Release sources, live in every mode
   assign ev_rel = (rx_error_release_enable & ev_err)
                 | ((rx_full_release_select == `SSWC_FULL_SEL_RXI) & ev_full);

   assign wr_standby = wr_i && (addr_i == `SSWC_OFS_CTRL)
                       && wbit(wdata_i, `SSWC_CTRL_STANDBY);

   // Next mode
   always @* begin
      next_mode = mode;
      case (mode)
         M_NORMAL: begin
            if (wr_standby)
               next_mode = M_STANDBY;
         end
         M_STANDBY: begin
            if (pin_fall && snz_capable)
               next_mode = M_SETTLE;
         end
         M_SETTLE: begin
            if (settle_cnt == SETTLE_LAST)
               next_mode = M_SNZ_RX;
         end
         // A glitch start bit leaves the receiver idle, so the next edge retries
         M_SNZ_RX: begin
            if (ev_rel)
               next_mode = M_NORMAL;
            else if (ev_end)
               next_mode = M_STANDBY;
            else if (!rx_busy && pin_fall)
               next_mode = M_SETTLE;
         end
         default: next_mode = M_NORMAL;
      endcase
   end

   // Mode register and settle timer
   // The timer restarts on every entry, so each snooze settles in full
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode       <= M_NORMAL;
         settle_cnt <= 16'h0000;
      end else begin
         mode <= next_mode;
         if (mode == M_SETTLE)
            settle_cnt <= settle_cnt + 16'h0001;
         else
            settle_cnt <= 16'h0000;
      end
   end

   // Clock tree and CPU state follow the mode
   // Taken from next_mode so clocks switch at the same edge as the mode
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_run_o            <= 1'b1;
         snooze_o             <= 1'b0;
         fast_onchip_osc_en_o <= 1'b1;
         slow_onchip_osc_en_o <= 1'b1;
         pll_en_o             <= 1'b1;
         main_clk_en_o        <= 1'b1;
      end else begin
         cpu_run_o            <= (next_mode == M_NORMAL);
         snooze_o             <= (next_mode == M_SETTLE) || (next_mode == M_SNZ_RX);
         fast_onchip_osc_en_o <= (next_mode != M_STANDBY);
         slow_onchip_osc_en_o <= (next_mode == M_NORMAL);
         pll_en_o             <= (next_mode == M_NORMAL);
         main_clk_en_o        <= (next_mode == M_NORMAL);
      end
   end

   // Receiver start: at once in normal mode, after settling in snooze.
   // In snooze the start bit is already under way, so timing resumes late.
   // Settling must end before the late start-bit sample, or that check is lost
   always @* begin
      rx_start   = 1'b0;
      rx_elapsed = 16'h0000;
      rx_late    = 1'b0;
      if (mode == M_NORMAL) begin
         rx_start = pin_fall;
      end else if (mode == M_SETTLE && settle_cnt == SETTLE_LAST) begin
         rx_start   = 1'b1;
         rx_elapsed = START_LAG;
         rx_late    = 1'b1;
      end else if (mode == M_SNZ_RX) begin
         rx_late    = 1'b1;
      end
   end

   sswc_rx #(
      .W         (16)
   ) u_rx (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .rx_i      (pin_s2),
      .start_i   (rx_start),
      .elapsed_i (rx_elapsed),
      .late_i    (rx_late),
      .div_i     (baud_div),
      .done_o    (rx_done),
      .err_o     (rx_ferr),
      .data_o    (rx_data),
      .busy_o    (rx_busy)
   );

   // Interrupt pulses: wake and its originating source in the same cycle
   // Both are registered, so the CPU sees them side by side on return
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         snooze_release_irq_o <= 1'b0;
         rx_full_irq_o        <= 1'b0;
         rx_err_irq_o         <= 1'b0;
      end else begin
         snooze_release_irq_o <= ev_rel & wake_irq_enable_bit;
         rx_full_irq_o        <= ev_full;
         rx_err_irq_o         <= ev_err;
      end
   end

   // Sticky status: a set in the cycle of the clearing read wins
   assign rd_stat  = rd_i && (addr_i == `SSWC_OFS_IRQ_STAT);
   assign stat_set = {ev_end, ev_err, ev_full, ev_rel & wake_irq_enable_bit};

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         irq_stat <= {`SSWC_ST_W{1'b0}};
      else if (rd_stat)
         irq_stat <= stat_set;
      else
         irq_stat <= irq_stat | stat_set;
   end

   assign irq_o = |(irq_stat & irq_mask);

   // Register writes
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         snz_sel                 <= `SSWC_SEL_OFF;
         async_mode              <= 1'b0;
         match_en                <= 1'b0;
         rx_error_release_enable <= 1'b0;
         rx_full_release_select  <= 2'h0;
         wake_irq_enable_bit     <= 1'b0;
         compare_data_value      <= 8'h00;
         baud_div                <= `SSWC_BAUD_RST;
         irq_mask                <= {`SSWC_ST_W{1'b0}};
      end else if (wr_i) begin
         case (addr_i)
            `SSWC_OFS_CTRL: begin
               snz_sel    <= wdata_i[`SSWC_CTRL_SEL_HI:`SSWC_CTRL_SEL_LO];
               async_mode <= wbit(wdata_i, `SSWC_CTRL_ASYNC);
               match_en   <= wbit(wdata_i, `SSWC_CTRL_MATCH);
            end
            `SSWC_OFS_RELSEL: begin
               rx_error_release_enable <= wbit(wdata_i, `SSWC_REL_ERR);
               rx_full_release_select  <= wdata_i[`SSWC_REL_FULL_HI:`SSWC_REL_FULL_LO];
            end
            `SSWC_OFS_IRQ_GRP: begin
               wake_irq_enable_bit <= wbit(wdata_i, `SSWC_IRQ_GRP_WAKE);
            end
            `SSWC_OFS_COMPARE: begin
               compare_data_value <= wdata_i[7:0];
            end
            `SSWC_OFS_BAUD: begin
               baud_div <= wdata_i[15:0];
            end
            `SSWC_OFS_IRQ_MASK: begin
               irq_mask <= wdata_i[`SSWC_ST_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Read data, one cycle after the strobe and zero otherwise
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         case (addr_i)
            `SSWC_OFS_CTRL:     rdata_o <= {27'h0000000, match_en, async_mode, snz_sel, 1'b0};
            `SSWC_OFS_RELSEL:   rdata_o <= {29'h00000000, rx_full_release_select,
                                            rx_error_release_enable};
            `SSWC_OFS_IRQ_GRP:  rdata_o <= {30'h00000000, wake_irq_enable_bit, 1'b0};
            `SSWC_OFS_COMPARE:  rdata_o <= {24'h000000, compare_data_value};
            `SSWC_OFS_BAUD:     rdata_o <= {16'h0000, baud_div};
            `SSWC_OFS_STATUS:   rdata_o <= {29'h00000000, rx_busy, mode};
            `SSWC_OFS_RXDATA:   rdata_o <= {24'h000000, rx_data};
            `SSWC_OFS_IRQ_STAT: rdata_o <= {28'h0000000, irq_stat};
            `SSWC_OFS_IRQ_MASK: rdata_o <= {28'h0000000, irq_mask};
            default:            rdata_o <= 32'h00000000;
         endcase
      end else begin
         rdata_o <= 32'h00000000;
      end
   end

endmodule // sswc_core

`default_nettype wire

// ==== rtl/sswc_map.vh ====
// Register map, field positions, reset values and timing counts for the
// serial snooze wake controller. Definitions only; included by bare name.
`ifndef SSWC_MAP_VH
`define SSWC_MAP_VH

// Clock and oscillator settling
`define SSWC_CLK_PERIOD_NS   25
`define SSWC_OSC_SETTLE_NS   50000
`define SSWC_OSC_SETTLE_CYC  ((`SSWC_OSC_SETTLE_NS + `SSWC_CLK_PERIOD_NS - 1) / `SSWC_CLK_PERIOD_NS)
`define SSWC_SYNC_LAT_CYC    3

// Only this channel number may wake the chip from standby
`define SSWC_SNZ_CHAN        5

// Register byte offsets
`define SSWC_OFS_CTRL        8'h00
`define SSWC_OFS_RELSEL      8'h04
`define SSWC_OFS_IRQ_GRP     8'h08
`define SSWC_OFS_COMPARE     8'h0c
`define SSWC_OFS_BAUD        8'h10
`define SSWC_OFS_STATUS      8'h14
`define SSWC_OFS_RXDATA      8'h18
`define SSWC_OFS_IRQ_STAT    8'h1c
`define SSWC_OFS_IRQ_MASK    8'h20

// Control register fields
`define SSWC_CTRL_STANDBY    0
`define SSWC_CTRL_SEL_LO     1
`define SSWC_CTRL_SEL_HI     2
`define SSWC_CTRL_ASYNC      3
`define SSWC_CTRL_MATCH      4

// Serial snooze select encodings
`define SSWC_SEL_OFF         2'h0
`define SSWC_SEL_MISMATCH    2'h2

// Release select fields
`define SSWC_REL_ERR         0
`define SSWC_REL_FULL_LO     1
`define SSWC_REL_FULL_HI     2
`define SSWC_FULL_SEL_RXI    2'h1

// Interrupt enable group: wake interrupt bit
`define SSWC_IRQ_GRP_WAKE    1

// Sticky status bits
`define SSWC_ST_WAKE         0
`define SSWC_ST_FULL         1
`define SSWC_ST_ERR          2
`define SSWC_ST_END          3
`define SSWC_ST_W            4

// Reset values
`define SSWC_BAUD_RST        16'h01b2
`define SSWC_CTRL_RST        5'h00

`endif

// ==== rtl/sswc_rx.v ====
// Asynchronous 8N1 character receiver for the snooze wake controller.
// Assumes rx_i is already synchronised to ref_clk_i and div_i >= 4.
`default_nettype none

module sswc_rx #(
   parameter W = 16                            // Width of bit timer
) (
   input  wire         ref_clk_i,              // Block clock
   input  wire         rst_n_i,                // Async reset, active low
   input  wire         rx_i,                   // Synchronised line level
   input  wire         start_i,                // Start edge seen, pulse
   input  wire [W-1:0] elapsed_i,              // Cycles already gone in start bit
   input  wire         late_i,                 // Sample late in each bit
   input  wire [W-1:0] div_i,                  // Cycles per bit
   output reg          done_o,                 // Character complete, pulse
   output reg          err_o,                  // Framing error with done_o
   output reg  [7:0]   data_o,                 // Received character
   output reg          busy_o                  // Character in progress
);

   reg  [W-1:0] cnt;
   reg  [3:0]   idx;
   reg  [7:0]   shift;
   wire [W-1:0] point;

   // Late point buys time for the wake path; it narrows the usable bit rate
   assign point = late_i ? (div_i - (div_i >> 2)) : (div_i >> 1);

   // Bit timer, shifter and stop-bit check
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt    <= {W{1'b0}};
         idx    <= 4'h0;
         shift  <= 8'h00;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         err_o  <= 1'b0;
         data_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         if (!busy_o) begin
            if (start_i) begin
               busy_o <= 1'b1;
               idx    <= 4'h0;
               cnt    <= elapsed_i;
            end
         end else begin
            if (cnt == div_i - 1'b1) begin
               cnt <= {W{1'b0}};
               idx <= idx + 4'h1;
            end else begin
               cnt <= cnt + 1'b1;
            end
            if (cnt == point) begin
               if (idx == 4'h0) begin
                  if (rx_i)
                     busy_o <= 1'b0;           // Glitch, not a start bit
               end else if (idx == 4'h9) begin
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  err_o  <= ~rx_i;
                  data_o <= shift;
               end else begin
                  shift <= {rx_i, shift[7:1]};
               end
            end
         end
      end
   end

endmodule // sswc_rx

`default_nettype wire

// ==== verification/sswc_tx_model.sv ====
// Remote transmitter model: drives the receive line with 8N1 frames.
// Assumes the bench keeps the bit divisor inside the snooze rate limit.
`default_nettype none

module sswc_tx_model (
   input  wire logic        ref_clk_i,  // Bench clock
   input  wire logic [15:0] div_i,      // Cycles per bit
   output var  logic        line_o      // Receive line, idle high
);
   timeunit 1ns;
   timeprecision 1ps;

   // Line idles high between frames, like a pulled-up receive pin
   initial line_o = 1'b1;

   // One frame, LSB first; a low stop bit provokes a framing error
   task automatic send(input logic [7:0] d, input logic bad_stop);
      logic [9:0] frame;
      frame = {~bad_stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk_i);
         line_o <= frame[i];
         repeat (div_i - 16'h1) @(posedge ref_clk_i);
      end
      @(posedge ref_clk_i);
      line_o <= 1'b1;
   endtask
endmodule // sswc_tx_model

`default_nettype wire

// ==== verification/sswc_core_chk.sv ====
// Checker for the snooze wake controller, bound to the top module.
// Assumes one clock domain and an active-low asynchronous reset.
`default_nettype none

module sswc_core_chk #(
   parameter int CHAN       = 5,    // Wake channel number
   parameter int SETTLE_CYC = 2000  // Oscillator settling, cycles
) (
   input wire logic        ref_clk_i,            // Block clock
   input wire logic        rst_n_i,              // Reset, active low
   input wire logic        rd_i,                 // Read strobe
   input wire logic [31:0] rdata_o,              // Read data
   input wire logic        serial_receive_pin_i, // Receive line
   input wire logic        snooze_release_irq_o, // Wake pulse
   input wire logic        rx_full_irq_o,        // Receive full pulse
   input wire logic        rx_err_irq_o,         // Receive error pulse
   input wire logic        cpu_run_o,            // Normal mode
   input wire logic        snooze_o,             // Snooze mode
   input wire logic        fast_onchip_osc_en_o, // Fast oscillator
   input wire logic        slow_onchip_osc_en_o, // Slow oscillator
   input wire logic        pll_en_o,             // PLL
   input wire logic        main_clk_en_o         // Main clock
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Read data stands only in the cycle after a read, so stale data never leaks
   rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not idle");
   osc_snooze_a: assert property (snooze_o |-> fast_onchip_osc_en_o && !slow_onchip_osc_en_o
      && !pll_en_o && !main_clk_en_o) else $error("wrong clocks in snooze");
   osc_standby_a: assert property (!cpu_run_o && !snooze_o |-> !fast_onchip_osc_en_o)
      else $error("fast oscillator on in standby");
   snooze_entry_a: assert property ($rose(snooze_o) |->
      !$past(serial_receive_pin_i) && !$past(cpu_run_o)) else $error("bad snooze entry");
   // Nothing is received in the first 8 cycles of oscillator settling
   settle_quiet_a: assert property ($rose(snooze_o) |->
      (snooze_o && !rx_full_irq_o && !rx_err_irq_o)[*8]) else $error("early reception");
   wake_source_a: assert property (snooze_release_irq_o |-> rx_full_irq_o || rx_err_irq_o)
      else $error("wake without source");
   release_mode_a: assert property ($rose(cpu_run_o) |-> $past(snooze_o) && !snooze_o)
      else $error("normal mode not from snooze");
   wake_return_a: assert property ($rose(cpu_run_o) |-> rx_full_irq_o || rx_err_irq_o)
      else $error("return without receive interrupt");
   standby_back_a: assert property ($fell(snooze_o) && !cpu_run_o |->
      !rx_full_irq_o && !snooze_release_irq_o) else $error("interrupt on return to standby");

   // Main scenarios
   cover property ($rose(snooze_o));
   cover property ($fell(snooze_o) && !cpu_run_o);
   cover property ($rose(cpu_run_o) && rx_err_irq_o);
   cover property (snooze_release_irq_o && $past(cpu_run_o));
endmodule // sswc_core_chk

bind sswc_core sswc_core_chk #(.CHAN(CHAN), .SETTLE_CYC(SETTLE_CYC)) u_sswc_core_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .serial_receive_pin_i(serial_receive_pin_i), .snooze_release_irq_o(snooze_release_irq_o),
   .rx_full_irq_o(rx_full_irq_o), .rx_err_irq_o(rx_err_irq_o), .cpu_run_o(cpu_run_o),
   .snooze_o(snooze_o), .fast_onchip_osc_en_o(fast_onchip_osc_en_o),
   .slow_onchip_osc_en_o(slow_onchip_osc_en_o), .pll_en_o(pll_en_o),
   .main_clk_en_o(main_clk_en_o));

`default_nettype wire

// ==== verification/sswc_core_bench.sv ====
// Self-checking bench for the snooze wake controller, one task per scenario.
// Assumes the transmitter model and the bound checker are compiled first.
`include "sswc_map.vh"
`default_nettype none

module sswc_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] DIV = 16'h01c2; // About 89 kbps at 40 MHz, inside the snooze limit
   logic        ref_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   wire  logic [31:0] rdata_o;
   wire  logic  line, irq_o, wake, full, err, cpu_run_o, snooze_o, fosc, sosc, pll, mclk;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          n_wake, n_full, n_err, n_snz;
   logic        snz_q = 1'b0;

   always #12.5 ref_clk_i = ~ref_clk_i;

   sswc_core #(.CHAN(5), .SETTLE_CYC(8)) u_sswc_core (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_receive_pin_i(line),
      .irq_o(irq_o), .snooze_release_irq_o(wake), .rx_full_irq_o(full), .rx_err_irq_o(err),
      .cpu_run_o(cpu_run_o), .snooze_o(snooze_o), .fast_onchip_osc_en_o(fosc),
      .slow_onchip_osc_en_o(sosc), .pll_en_o(pll), .main_clk_en_o(mclk));
   sswc_tx_model u_sswc_tx_model (.ref_clk_i(ref_clk_i), .div_i(DIV), .line_o(line));

   // Tally pulses and snooze entries; scenarios judge the totals afterwards
   always @(posedge ref_clk_i) begin
      n_wake += int'(wake === 1'b1);
      n_full += int'(full === 1'b1);
      n_err += int'(err === 1'b1);
      n_snz += int'(snooze_o === 1'b1 && snz_q === 1'b0);
      snz_q = snooze_o;
   end

   task automatic clr;
      n_wake = 0;
      n_full = 0;
      n_err = 0;
      n_snz = 0;
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic miss(input string m, input logic [31:0] g, input logic [31:0] e);
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      samples_checked++;
      if (d !== e) miss("register", d, e);
   endtask

   // Callers arrive 1 ns past an edge, so the value passed in has settled
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) miss("value", g, e);
   endtask

   // Receiver busy is polled with a bound, so a stuck frame cannot hang the run
   task automatic send(input logic [7:0] d, input logic bad);
      logic [31:0] s;
      clr;
      u_sswc_tx_model.send(d, bad);
      s = 32'h4;
      for (int i = 0; i < 300 && s[2] !== 1'b0; i++) rd(`SSWC_OFS_STATUS, s);
      if (s[2] !== 1'b0) begin
         miss("receiver busy", s, 32'h0);
         end_of_test;
      end
   endtask

   task automatic do_reset;
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
   endtask

   task automatic t_reset;
      wr(8'h24, 32'hffff_ffff);
      chk_reg(8'h24, 32'h0);
      chk_reg(`SSWC_OFS_STATUS, 32'h0);
      chk_reg(`SSWC_OFS_BAUD, {16'h0, `SSWC_BAUD_RST});
      chk_reg(`SSWC_OFS_CTRL, 32'h0);
      chk_val({cpu_run_o, fosc, sosc, pll, mclk}, 32'h1f);
   endtask

   task automatic t_normal;
      wr(`SSWC_OFS_BAUD, {16'h0, DIV});
      wr(`SSWC_OFS_RELSEL, 32'h2);
      wr(`SSWC_OFS_IRQ_GRP, 32'h2);
      wr(`SSWC_OFS_IRQ_MASK, 32'h0);
      send(8'ha5, 1'b0);
      chk_val(n_full, 1);
      chk_val(n_wake, 1);
      chk_val(irq_o, 0);
      chk_reg(`SSWC_OFS_RXDATA, 32'ha5);
      wr(`SSWC_OFS_IRQ_MASK, 32'h2);
      chk_val(irq_o, 1);
      chk_reg(`SSWC_OFS_IRQ_STAT, 32'h3);
      chk_val(irq_o, 0);
      chk_reg(`SSWC_OFS_IRQ_STAT, 32'h0);
   endtask

   task automatic t_snooze_full;
      wr(`SSWC_OFS_CTRL, 32'h0b);
      chk_val({cpu_run_o, fosc}, 0);
      chk_reg(`SSWC_OFS_STATUS, 32'h1);
      send(8'h3c, 1'b0);
      chk_val(n_snz, 1);
      chk_val(n_wake, 1);
      chk_val(n_full, 1);
      chk_val(cpu_run_o, 1);
      chk_reg(`SSWC_OFS_RXDATA, 32'h3c);
      chk_reg(`SSWC_OFS_IRQ_STAT, 32'h3);
   endtask

   task automatic t_mismatch;
      wr(`SSWC_OFS_COMPARE, 32'h5a);
      wr(`SSWC_OFS_CTRL, 32'h1d);
      send(8'h11, 1'b0);
      chk_reg(`SSWC_OFS_STATUS, 32'h1);
      chk_val(n_full + n_wake, 0);
      send(8'h5a, 1'b0);
      chk_val(n_wake, 1);
      chk_reg(`SSWC_OFS_STATUS, 32'h0);
      chk_reg(`SSWC_OFS_IRQ_STAT, 32'hb);
   endtask

   task automatic t_err;
      wr(`SSWC_OFS_CTRL, 32'h0b);
      wr(`SSWC_OFS_RELSEL, 32'h1);
      send(8'h77, 1'b1);
      chk_val(n_err, 1);
      chk_val(n_wake, 1);
      chk_val(cpu_run_o, 1);
   endtask

   task automatic t_stay;
      wr(`SSWC_OFS_IRQ_GRP, 32'h0);
      wr(`SSWC_OFS_RELSEL, 32'h0);
      wr(`SSWC_OFS_CTRL, 32'h0b);
      send(8'h42, 1'b0);
      chk_reg(`SSWC_OFS_STATUS, 32'h3);
      chk_val({cpu_run_o, snooze_o}, 1);
      wr(`SSWC_OFS_RELSEL, 32'h2);
      send(8'h24, 1'b0);
      chk_val(n_full, 1);
      chk_val(n_wake, 0);
      chk_val(cpu_run_o, 1);
   endtask

   task automatic t_sync;
      wr(`SSWC_OFS_CTRL, 32'h03);
      send(8'h66, 1'b0);
      chk_reg(`SSWC_OFS_STATUS, 32'h1);
      chk_val(n_snz, 0);
      @(posedge ref_clk_i);
      do_reset;
      t_reset;
   endtask

   // Watchdog for the whole run
   initial begin
      #2000000;
      miss("run time", 32'h0, 32'h0);
      end_of_test;
   end

   initial begin
      do_reset;
      t_reset;
      t_normal;
      t_snooze_full;
      t_mismatch;
      t_err;
      t_stay;
      t_sync;
      end_of_test;
   end
endmodule // sswc_core_bench

`default_nettype wire
